// File: bench/cbtm_assertions.sv
// Port checks of the CAN transmit block
`timescale 1ns/1ns
module cbtm_assertions
  import cbtm_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        can_rx_i,
  input wire logic        can_tx_o,
  input wire logic        standby_exit_i
);
  // ****
  // Helpers
  // ****
  logic rq;
  logic rd;
  logic cfg_q;
  // A fresh request and a fresh read
  assign rq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = rq && !wb_we_i;
  // Set by hard reset only, since a software request may wait out a frame
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q <= 1'b1;
    end else if (rq && wb_we_i && wb_adr_i == OFF_MCR && wb_sel_i[0] && !wb_dat_i[0]) begin
      cfg_q <= 1'b0;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_NEXT: assert property (rq |=> wb_ack_o)
    else $error("ack missing");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  AST_HOLE: assert property (rd && wb_adr_i == 12'h0FC |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_MB0_NO_TX: assert property (rd && wb_adr_i == OFF_TXBUF |=> !(wb_dat_o[4] && wb_dat_o[3:0] == 4'h0))
    else $error("receive mailbox buffered");
  AST_CFG_STATE: assert property (rd && wb_adr_i == OFF_GSR && cfg_q |=> wb_dat_o[GSR_RST_STATE])
    else $error("state bit low in config");
  AST_CFG_QUIET: assert property (cfg_q |-> can_tx_o)
    else $error("sent in config");
  AST_BIT_LEN: assert property ($changed(can_tx_o) |=> $stable(can_tx_o) [*5])
    else $error("bit too short");
endmodule

bind cbtm_top cbtm_assertions u_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .can_rx_i(can_rx_i), .can_tx_o(can_tx_o), .standby_exit_i(standby_exit_i)
);

// File: bench/cbtm_can_node.sv
// Other CAN node on a wired-AND bus
`timescale 1ns/1ns
module cbtm_can_node (
  input  wire logic can_tx_i,
  input  wire logic hold_dom_i,
  output logic      can_bus_o
);
  // Pull-up makes the idle bus recessive; holding dominant blocks idle detection
  assign can_bus_o = can_tx_i & ~hold_dom_i;
endmodule

// File: bench/tb_top.sv
// Self-checking bench of the CAN transmit block
`timescale 1ns/1ns
module tb_top;
  import cbtm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = '0;
  logic [31:0] wd = '0;
  logic [3:0]  sel = '0;
  logic        stby = 1'b0;
  logic        hold = 1'b0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic        tx;
  logic        rx;
  int          n_errors = 0;
  int          total_checks = 0;
  int          ticks = 0;
  int          bl;
  int          cnt;
  int          mbx[4] = '{3, 5, 7, 9};
  // Mailbox 9 carries an extended identifier whose base part is 600
  logic [31:0] ids[4] = '{32'h700, 32'h500, 32'h401, 32'h1600};

  cbtm_top dut (
    .sys_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .can_rx_i(rx), .can_tx_o(tx),
    .standby_exit_i(stby)
  );
  cbtm_can_node peer (.can_tx_i(tx), .hold_dom_i(hold), .can_bus_o(rx));

  // 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end
  // Both rounds need about 12000 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    ticks++;
    if (ticks == 60000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  // Classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk($sformatf("reg %h", a), q & m, e);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Round 0 orders by mailbox number, round 1 by identifier, each at its own rate
  initial begin
    for (int m = 0; m < 2; m++) begin
      bl = 2 * (m + 1) * (3 + (2 + m) + (1 + m));
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rc(OFF_MCR, 32'h1, 32'h1);
      rc(OFF_GSR, 32'h8, 32'h8);
      rc(OFF_MAILBOX_DIRECTION_REG, 32'hFFFF, 32'h0);
      rc(OFF_MAILBOX_IRQ_MASK_REG, 32'hFFFF, 32'hFFFF);
      wb(1'b1, OFF_IMR, 32'h5A5A);
      rc(OFF_IMR, 32'hFFFF, 32'h5A5A);
      rc(12'h0FC, '1, 32'h0);
      rc(OFF_IRR, 32'h1, 32'h1);
      wb(1'b1, OFF_IRR, 32'h1);
      rc(OFF_IRR, 32'h1, 32'h0);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      rc(OFF_IRR, 32'h1, 32'h1);
      wb(1'b1, OFF_BCR, 32'(m + ((2 + m) << 8) + ((1 + m) << 12)));
      // Mailbox 7 receives, so its low identifier must never win
      for (int i = 0; i < 4; i++) begin
        wb(1'b1, OFF_MB_BASE + 12'(16 * mbx[i]), 32'h2);
        wb(1'b1, OFF_MB_BASE + 12'(16 * mbx[i] + 4), ids[i] << 18);
      end
      wb(1'b1, OFF_MAILBOX_DIRECTION_REG, 32'hA080);
      wb(1'b1, OFF_MCR, 32'(1 + 4 * m));
      wb(1'b1, OFF_PENDING_TRANSMIT_REG, 32'h281);
      rc(OFF_TXBUF, 32'h1F, 32'h19);
      wb(1'b1, OFF_PENDING_TRANSMIT_REG, 32'h20);
      rc(OFF_TXBUF, 32'h1F, 32'h15);
      wb(1'b1, OFF_PENDING_TRANSMIT_REG, 32'h8);
      rc(OFF_TXBUF, 32'h1F, m ? 32'h15 : 32'h13);
      // Leave config with the bus held dominant: nothing may start
      hold <= 1'b1;
      wb(1'b1, OFF_MCR, 32'(4 * m));
      repeat (20 * bl) @(posedge clk);
      chk("tx held", 32'(tx), 32'h1);
      hold <= 1'b0;
      cnt = 0;
      while (tx !== 1'b0) begin
        @(posedge clk);
        cnt++;
      end
      chk("idle wait", 32'(cnt >= 10 * bl), 32'h1);
      cnt = 0;
      do begin
        @(posedge clk);
        cnt++;
      end while (tx === 1'b0);
      chk("start bit", 32'(cnt), 32'(bl));
      rc(OFF_GSR, 32'h4, 32'h4);
      do wb(1'b0, OFF_PENDING_TRANSMIT_REG, '0); while ((q & 32'h228) == 32'h228);
      chk("first sent", q & 32'h228, m ? 32'h208 : 32'h220);
      do wb(1'b0, OFF_PENDING_TRANSMIT_REG, '0); while ((q & 32'h228) != 32'h0);
      rc(OFF_TXBUF, 32'h10, 32'h0);
      rc(OFF_GSR, 32'h5, 32'h1);
      wb(1'b1, OFF_MCR, 32'h1);
      rc(OFF_MAILBOX_DIRECTION_REG, 32'hFFFE, 32'hA080);
      $display("round %0d done", m);
    end
    close_out();
  end
endmodule

// File: verilog/cbtm_bit_timer.sv
// Time quantum and bit period generator of the CAN transmit block
`timescale 1ns/1ns
module cbtm_bit_timer
  import cbtm_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       run_i,
  input  wire logic [5:0] prescaler_value_i,
  input  wire logic [3:0] segment_one_len_i,
  input  wire logic [2:0] segment_two_len_i,
  output logic            bit_start_o,
  output logic            sample_o
);

  typedef struct packed {
    logic [6:0] pre;
    logic [4:0] tq;
    logic       start;
    logic       smp;
  } cbtm_bt_s;

  cbtm_bt_s   q;
  cbtm_bt_s   d;
  logic [6:0] pre_last;
  logic [4:0] tq_last;
  logic [4:0] tq_smp;

  // Quantum is 2*(n+1) clocks; bit is sync + seg1 + seg2 quanta
  always_comb begin
    d        = q;
    d.start  = 1'b0;
    d.smp    = 1'b0;
    pre_last = {prescaler_value_i, 1'b1}; // R1
    tq_smp   = SYNC_TQ + 5'(segment_one_len_i); // R25
    tq_last  = tq_smp + SEG_BIAS + 5'(segment_two_len_i); // R2
    if (!run_i) begin
      d.pre = '0;
      d.tq  = '0;
    end else if (q.pre == pre_last) begin
      d.pre = '0;
      d.smp = (q.tq == tq_smp); // Sample at end of segment one
      if (q.tq == tq_last) begin
        d.tq    = '0;
        d.start = 1'b1;
      end else begin
        d.tq = q.tq + 5'h01;
      end
    end else begin
      d.pre = q.pre + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_start_o = q.start;
  assign sample_o    = q.smp;

endmodule

// File: verilog/cbtm_pkg.sv
// Shared constants and types of the CAN bit timing, mailbox and transmit block
package cbtm_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_MB   = 16;
  localparam int unsigned MB_WORDS = 4;
  localparam int unsigned SH_W     = 102;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFF_MCR     = 12'h000;
  localparam logic [11:0] OFF_GSR     = 12'h004;
  localparam logic [11:0] OFF_BCR     = 12'h008;
  localparam logic [11:0] OFF_MAILBOX_DIRECTION_REG    = 12'h00C;
  localparam logic [11:0] OFF_PENDING_TRANSMIT_REG    = 12'h010;
  localparam logic [11:0] OFF_MAILBOX_IRQ_MASK_REG   = 12'h014;
  localparam logic [11:0] OFF_IMR     = 12'h018;
  localparam logic [11:0] OFF_IRR     = 12'h01C;
  localparam logic [11:0] OFF_TXBUF   = 12'h020;
  localparam logic [11:0] OFF_MB_BASE = 12'h100;
  localparam logic [11:0] OFF_MB_LAST = 12'h1FC;
  localparam int unsigned MB_IDX_LSB  = 4;
  localparam int unsigned MB_WRD_LSB  = 2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned MCR_RESET_REQ = 0;
  localparam int unsigned MCR_TX_METHOD = 2;
  localparam int unsigned GSR_BUS_IDLE  = 0;
  localparam int unsigned GSR_TX_BUSY   = 2;
  localparam int unsigned GSR_RST_STATE = 3;
  localparam int unsigned BCR_BRP_LSB   = 0;
  localparam int unsigned BCR_SEGMENT_ONE_LEN_LSB = 8;
  localparam int unsigned BCR_SEGMENT_TWO_LEN_LSB = 12;
  localparam int unsigned BCR_SJW_LSB   = 16;
  localparam int unsigned IRR_RST_FLAG  = 0;
  localparam int unsigned TXBUF_VLD     = 4;
  localparam int unsigned MBW_CTRL      = 0;
  localparam int unsigned MBW_ARB       = 1;
  localparam int unsigned MBW_D0        = 2;
  localparam int unsigned MBW_D1        = 3;
  localparam int unsigned DLC_LSB       = 0;
  localparam int unsigned ARB_EXT_LSB   = 0;
  localparam int unsigned ARB_STD_LSB   = 18;
  localparam int unsigned ARB_RTR       = 29;
  localparam int unsigned ARB_IDE       = 30;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic [15:0] MAILBOX_DIRECTION_REG_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST   = 16'hFFFF;
  localparam logic [3:0]  IDLE_BITS  = 4'hB;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;
  localparam logic [6:0]  HDR_STD    = 7'h12;
  localparam logic [6:0]  HDR_EXT    = 7'h26;
  localparam logic [6:0]  CRC_LEN    = 7'h0F;
  localparam logic [6:0]  TAIL_LEN   = 7'h0D;
  localparam logic [14:0] CRC_POLY   = 15'h4599;
  localparam logic [3:0]  MAX_BYTES  = 4'h8;
  localparam logic [4:0]  SYNC_TQ    = 5'h01;
  localparam logic [4:0]  SEG_BIAS   = 5'h01;
  localparam logic        DOMINANT   = 1'b0;
  localparam logic        RECESSIVE  = 1'b1;

  typedef enum logic [1:0] {CBTM_CFG, CBTM_PWRUP, CBTM_RUN} cbtm_mode_e;
  typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_CRC, TX_TAIL} cbtm_tx_e;

endpackage

// File: verilog/cbtm_top.sv
// CAN bit timing, mailbox store and transmit path with a Wishbone register port
//
// Functional notes
// R1: One time quantum lasts 2*(prescaler_value+1) peripheral clocks.
// R2: One bit lasts 3 + segment one + segment two field quanta.
// R3: Software keeps resync jump width between 1 and 4 quanta.
// R4: Software keeps segment two at least one quantum above jump width.
// R5: Timing fields come from bit_config_reg; clock is the peripheral clock.
// R6: Sixteen mailboxes; mailbox 0 only receives, 1 to 15 configurable.
// R7: Direction bit 1 means receive, 0 means transmit.
// R8: After reset every direction bit is 0 (transmit).
// R9: Software reset request leaves direction bits untouched.
// R10: Software writes every mailbox before use; storage is undefined.
// R11: transmit_method_bit picks mailbox-number or identifier ordering.
// R12: Number mode: lowest pending mailbox loads first, 1 highest.
// R13: Identifier mode: highest bus priority identifier loads first.
// R14: Each newly set pending bit reruns arbitration and reloads buffer.
// R15: Only mailboxes 1 to 15 ever transmit.
// R16: Software fills a mailbox, then sets its pending bit to start.
// R17: Arbitration field sits in control bytes 5 to 8, std or ext.
// R18: Data length code sits in four bits of control byte 1.
// R19: Only DLC bytes, at most 8, of the data bytes are sent.
// R20: Per-mailbox and per-source interrupt masks are held in registers.
// R21: Reset interrupt flag sets on power-on reset and standby exit.
// R22: Software clears the reset flag before enabling interrupts.
// R23: Software initialises only while in configuration mode.
// R24: Config mode while reset request set; leaving waits 11 recessive bits. A software request takes effect from run mode only, once no frame is running.
// R25: Segment fields are one less than the segment length in quanta.
`timescale 1ns/1ns
module cbtm_top
  import cbtm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        can_rx_i,
  output logic             can_tx_o,
  input  wire logic        standby_exit_i
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                                   ack;
    logic [31:0]                            rdat;
    logic                                   rst_req;
    logic                                   tx_method;
    logic                                   rst_state;
    logic [5:0]                             prescaler_value;
    logic [3:0]                             segment_one_len;
    logic [2:0]                             segment_two_len;
    logic [1:0]                             resync_jump_width;
    logic [15:0]                            mbdir;
    logic [15:0]                            txpend;
    logic [15:0]                            mbmask;
    logic [15:0]                            imask;
    logic                                   irq_rst;
    logic [NUM_MB-1:0][MB_WORDS-1:0][31:0]  mem;
    cbtm_mode_e                             mode;
    cbtm_tx_e                               txs;
    logic                                   rx_meta;
    logic                                   rx_s;
    logic [3:0]                             idle_cnt;
    logic                                   buf_vld;
    logic [3:0]                             buf_idx;
    logic                                   pend_new;
    logic [SH_W-1:0]                        sh;
    logic [6:0]                             nleft;
    logic [14:0]                            crc;
    logic [2:0]                             run;
    logic                                   last;
    logic                                   tx;
  } cbtm_top_s;

  cbtm_top_s                 q;
  cbtm_top_s                 d;
  logic                      bt_start;
  logic                      bt_smp;
  logic                      sel_vld;
  logic [3:0]                sel_idx;
  logic [NUM_MB-1:0]         cand;
  logic [NUM_MB-1:0][31:0]   arb_words;
  logic [11:0]               a;
  logic                      acc;
  logic                      wr;
  logic                      in_mb;
  logic [3:0]                a_mb;
  logic [1:0]                a_w;
  logic [31:0]               wm;
  logic [31:0]               rd;
  logic [31:0]               arb;
  logic [31:0]               ctl;
  logic [3:0]                dlc;
  logic [3:0]                nbytes;
  logic [63:0]               data64;
  logic [SH_W-1:0]           fr_bits;
  logic [6:0]                fr_len;
  logic                      bitv;
  logic [14:0]               crc_n;

  // Byte-lane merge for partial Wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[b*8 +: 8] = n[b*8 +: 8];
      end
    end
  endfunction

  // ****************************************
  // Bit timing and internal arbitration
  // ****************************************
  cbtm_bit_timer u_timer (
    .sys_clk_i         (sys_clk_i),
    .reset_i           (reset_i),
    .run_i             (q.mode != CBTM_CFG),
    .prescaler_value_i (q.prescaler_value), // R5
    .segment_one_len_i (q.segment_one_len),
    .segment_two_len_i (q.segment_two_len),
    .bit_start_o       (bt_start),
    .sample_o          (bt_smp)
  );

  // Candidates: pending, set for transmit, and never mailbox 0
  for (genvar g = 0; g < NUM_MB; g++) begin : g_cand
    assign cand[g]      = (g != 0) && q.txpend[g] && !q.mbdir[g]; // R6 R15
    assign arb_words[g] = q.mem[g][MBW_ARB];
  end

  cbtm_tx_select u_select (
    .method_i (q.tx_method),
    .cand_i   (cand),
    .arb_i    (arb_words),
    .valid_o  (sel_vld),
    .idx_o    (sel_idx)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    d       = q;
    bitv    = 1'b0;
    crc_n   = q.crc;
    a       = {wb_adr_i[11:2], 2'b00};
    acc     = wb_cyc_i & wb_stb_i & ~q.ack;
    wr      = acc & wb_we_i;
    in_mb   = (a >= OFF_MB_BASE) && (a <= OFF_MB_LAST);
    a_mb    = a[MB_IDX_LSB +: 4];
    a_w     = a[MB_WRD_LSB +: 2];
    wm      = merge(32'h00000000, wb_dat_i, wb_sel_i);

    // Frame image of the buffered mailbox, SOF excluded
    arb     = q.mem[q.buf_idx][MBW_ARB]; // R17
    ctl     = q.mem[q.buf_idx][MBW_CTRL];
    dlc     = ctl[DLC_LSB +: 4]; // R18
    nbytes  = arb[ARB_RTR] ? 4'h0 : ((dlc > MAX_BYTES) ? MAX_BYTES : dlc); // R19
    for (int b = 0; b < 4; b++) begin
      data64[63 - b*8 -: 8] = q.mem[q.buf_idx][MBW_D0][b*8 +: 8];
      data64[31 - b*8 -: 8] = q.mem[q.buf_idx][MBW_D1][b*8 +: 8];
    end
    if (arb[ARB_IDE]) begin
      fr_bits = {arb[ARB_STD_LSB +: 11], RECESSIVE, RECESSIVE, arb[ARB_EXT_LSB +: 18],
                 arb[ARB_RTR], DOMINANT, DOMINANT, dlc, data64};
      fr_len  = HDR_EXT + 7'({nbytes, 3'b000});
    end else begin
      fr_bits = {arb[ARB_STD_LSB +: 11], arb[ARB_RTR], DOMINANT, DOMINANT, dlc, data64,
                 20'h00000};
      fr_len  = HDR_STD + 7'({nbytes, 3'b000});
    end

    // Register read image
    rd = 32'h00000000;
    unique case (a)
      OFF_MCR: begin
        rd[MCR_RESET_REQ] = q.rst_req;
        rd[MCR_TX_METHOD] = q.tx_method;
      end
      OFF_GSR: begin
        rd[GSR_BUS_IDLE]  = (q.idle_cnt == IDLE_BITS);
        rd[GSR_TX_BUSY]   = (q.txs != TX_IDLE);
        rd[GSR_RST_STATE] = q.rst_state;
      end
      OFF_BCR: begin
        rd[BCR_BRP_LSB +: 6]   = q.prescaler_value;
        rd[BCR_SEGMENT_ONE_LEN_LSB +: 4] = q.segment_one_len;
        rd[BCR_SEGMENT_TWO_LEN_LSB +: 3] = q.segment_two_len;
        rd[BCR_SJW_LSB +: 2]   = q.resync_jump_width;
      end
      OFF_MAILBOX_DIRECTION_REG:  rd[15:0] = q.mbdir;
      OFF_PENDING_TRANSMIT_REG:  rd[15:0] = q.txpend;
      OFF_MAILBOX_IRQ_MASK_REG: rd[15:0] = q.mbmask;
      OFF_IMR:   rd[15:0] = q.imask;
      OFF_IRR:   rd[IRR_RST_FLAG] = q.irq_rst;
      OFF_TXBUF: rd[TXBUF_VLD:0] = {q.buf_vld, q.buf_idx};
      default: begin
        if (in_mb) begin
          rd = q.mem[a_mb][a_w];
        end
      end
    endcase

    // Single-cycle answer; unmapped reads return zero
    d.ack  = acc;
    d.rdat = (acc && !wb_we_i) ? rd : 32'h00000000;

    // Pin sample: two flops before anything looks at the bus
    d.rx_meta = can_rx_i;
    d.rx_s    = q.rx_meta;

    // Count consecutive recessive bits at each sample point
    if (bt_smp) begin
      if (!q.rx_s) begin
        d.idle_cnt = '0;
      end else if (q.idle_cnt != IDLE_BITS) begin
        d.idle_cnt = q.idle_cnt + 4'h1;
      end
    end

    // Operating mode
    unique case (q.mode)
      CBTM_CFG: begin
        if (!q.rst_req) begin
          d.mode      = CBTM_PWRUP; // R24
          d.rst_state = 1'b0;
          d.idle_cnt  = '0;
        end
      end
      CBTM_PWRUP: begin
        if (q.idle_cnt == IDLE_BITS) begin
          d.mode = CBTM_RUN; // R24
        end
      end
      CBTM_RUN: begin
        // A request raised mid-frame waits for the frame to finish
        if (q.rst_req && q.txs == TX_IDLE) begin
          d.mode      = CBTM_CFG; // R24 R9
          d.rst_state = 1'b1;
        end
      end
    endcase

    // Transmit sequencer
    unique case (q.txs)
      TX_IDLE: begin
        if (q.buf_vld && !cand[q.buf_idx]) begin
          d.buf_vld = 1'b0;
        end
        if (q.pend_new || !q.buf_vld) begin
          d.buf_vld  = sel_vld; // R14
          d.buf_idx  = sel_idx;
          d.pend_new = 1'b0;
        end
        // Never start from a buffer that is being reloaded in this cycle
        if (bt_start && q.mode == CBTM_RUN && !q.rst_req && q.buf_vld && cand[q.buf_idx] &&
            !q.pend_new && q.idle_cnt == IDLE_BITS) begin
          d.txs   = TX_BODY; // R16
          d.tx    = DOMINANT;
          d.last  = DOMINANT;
          d.run   = 3'h1;
          d.crc   = '0;
          d.sh    = fr_bits;
          d.nleft = fr_len;
        end
      end
      TX_BODY, TX_CRC: begin
        // Lost arbitration or bit error: drop off, mailbox stays pending
        if (bt_smp && q.rx_s != q.tx) begin
          d.txs = TX_IDLE;
          d.tx  = RECESSIVE;
        end else if (bt_start) begin
          if (q.run == STUFF_RUN) begin
            d.tx   = ~q.last;
            d.last = ~q.last;
            d.run  = 3'h1;
          end else if (q.txs == TX_CRC && q.nleft == 7'h00) begin
            d.txs   = TX_TAIL;
            d.tx    = RECESSIVE;
            d.nleft = TAIL_LEN - 7'h01;
          end else begin
            bitv    = q.sh[SH_W-1];
            d.tx    = bitv;
            d.sh    = {q.sh[SH_W-2:0], 1'b0};
            d.nleft = q.nleft - 7'h01;
            d.run   = (bitv == q.last) ? q.run + 3'h1 : 3'h1;
            d.last  = bitv;
            if (q.txs == TX_BODY) begin
              crc_n = {q.crc[13:0], 1'b0} ^ ((bitv ^ q.crc[14]) ? CRC_POLY : 15'h0000);
              d.crc = crc_n;
              if (q.nleft == 7'h01) begin
                d.txs   = TX_CRC;
                d.sh    = {crc_n, 87'h0};
                d.nleft = CRC_LEN;
              end
            end
          end
        end
      end
      TX_TAIL: begin
        // Delimiters, acknowledge slot, end of frame and gap, all recessive
        if (bt_start) begin
          if (q.nleft == 7'h00) begin
            d.txs              = TX_IDLE;
            d.txpend[q.buf_idx] = 1'b0;
            d.buf_vld          = 1'b0;
          end else begin
            d.nleft = q.nleft - 7'h01;
          end
        end
      end
    endcase

    // Register writes; sets land after hardware clears so they win
    if (wr) begin
      unique case (a)
        OFF_MCR: begin
          d.rst_req   = wm[MCR_RESET_REQ] | (q.rst_req & ~wb_sel_i[0]);
          d.tx_method = wb_sel_i[0] ? wm[MCR_TX_METHOD] : q.tx_method; // R11
        end
        OFF_BCR: begin
          wm      = merge({14'h0000, q.resync_jump_width, 1'b0, q.segment_two_len, q.segment_one_len, 2'b00, q.prescaler_value},
                          wb_dat_i, wb_sel_i);
          d.prescaler_value   = wm[BCR_BRP_LSB +: 6]; // R5
          d.segment_one_len = wm[BCR_SEGMENT_ONE_LEN_LSB +: 4];
          d.segment_two_len = wm[BCR_SEGMENT_TWO_LEN_LSB +: 3];
          d.resync_jump_width   = wm[BCR_SJW_LSB +: 2];
        end
        OFF_MAILBOX_DIRECTION_REG: begin
          wm      = merge({16'h0000, q.mbdir}, wb_dat_i, wb_sel_i);
          d.mbdir = wm[15:0]; // R7
        end
        OFF_PENDING_TRANSMIT_REG: begin
          d.txpend = d.txpend | wm[15:0]; // R16
          if ((wm[15:0] & ~q.txpend) != 16'h0000) begin
            d.pend_new = 1'b1; // R14
          end
        end
        OFF_MAILBOX_IRQ_MASK_REG: begin
          wm       = merge({16'h0000, q.mbmask}, wb_dat_i, wb_sel_i);
          d.mbmask = wm[15:0]; // R20
        end
        OFF_IMR: begin
          wm      = merge({16'h0000, q.imask}, wb_dat_i, wb_sel_i);
          d.imask = wm[15:0]; // R20
        end
        OFF_IRR: begin
          if (wm[IRR_RST_FLAG]) begin
            d.irq_rst = 1'b0;
          end
        end
        default: begin
          if (in_mb) begin
            d.mem[a_mb][a_w] = merge(q.mem[a_mb][a_w], wb_dat_i, wb_sel_i);
          end
        end
      endcase
    end

    // Standby recovery re-arms the reset flag over a clear
    if (standby_exit_i) begin
      d.irq_rst = 1'b1; // R21
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Mailbox storage is cleared only to keep simulation defined
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q           <= '0;
      q.rst_req   <= 1'b1; // R24
      q.rst_state <= 1'b1;
      q.irq_rst   <= 1'b1; // R21
      q.mbdir     <= MAILBOX_DIRECTION_REG_RST; // R8
      q.mbmask    <= MASK_RST;
      q.imask     <= MASK_RST;
      q.tx        <= RECESSIVE;
      q.rx_meta   <= RECESSIVE;
      q.rx_s      <= RECESSIVE;
      q.last      <= RECESSIVE;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign can_tx_o = q.tx;

endmodule

// File: verilog/cbtm_tx_select.sv
// Internal arbitration picking the next mailbox for the transmit buffer
`timescale 1ns/1ns
module cbtm_tx_select
  import cbtm_pkg::*;
(
  input  wire logic                        method_i,
  input  wire logic [NUM_MB-1:0]           cand_i,
  input  wire logic [NUM_MB-1:0][31:0]     arb_i,
  output logic                             valid_o,
  output logic [3:0]                       idx_o
);

  logic [NUM_MB:0]        ch_v;
  logic [NUM_MB:0][3:0]   ch_i;
  logic [NUM_MB:0][31:0]  ch_k;

  // Key in bus order: lower key wins the bus, so lower key goes first
  function automatic logic [31:0] id_key(input logic [31:0] a);
    logic ide;
    ide    = a[ARB_IDE];
    id_key = {a[ARB_STD_LSB +: 11], ide ? 1'b1 : a[ARB_RTR], ide,
              ide ? a[ARB_EXT_LSB +: 18] : 18'h00000, ide & a[ARB_RTR]};
  endfunction

  assign ch_v[0] = 1'b0;
  assign ch_i[0] = '0;
  assign ch_k[0] = '0;

  // Strict compare keeps the lower mailbox on equal keys
  for (genvar g = 0; g < NUM_MB; g++) begin : g_arb
    logic [31:0] key;
    logic        take;
    assign key      = method_i ? id_key(arb_i[g]) : {28'h0000000, 4'(g)}; // R11 R12 R13
    assign take     = cand_i[g] && (!ch_v[g] || key < ch_k[g]);
    assign ch_v[g+1] = ch_v[g] | cand_i[g];
    assign ch_i[g+1] = take ? 4'(g) : ch_i[g];
    assign ch_k[g+1] = take ? key : ch_k[g];
  end

  assign valid_o = ch_v[NUM_MB];
  assign idx_o   = ch_i[NUM_MB];

endmodule
